// >>> src/sssp_pkg.sv
package sssp_pkg;
  // word size and master edge bookkeeping
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [4:0] LAST_LEAD = 5'h0e;
  localparam logic [4:0] LAST_TRAIL = 5'h0f;
  // half bit periods in sys_clk cycles (sys_clk is the oscillator)
  localparam logic [5:0] HALF_DIV4 = 6'h02;
  localparam logic [5:0] HALF_DIV16 = 6'h08;
  localparam logic [5:0] HALF_DIV64 = 6'h20;
  // master rate select codes
  localparam logic [1:0] RATE_DIV4 = 2'h0;
  localparam logic [1:0] RATE_DIV16 = 2'h1;
  localparam logic [1:0] RATE_DIV64 = 2'h2;
  localparam logic [1:0] RATE_TMR2 = 2'h3;
  // direction bit positions in the port direction words
  localparam int DIR_C_SCK = 3;
  localparam int DIR_C_SDI = 4;
  localparam int DIR_C_SDO = 5;
  localparam int DIR_A_SS = 5;

  // port_control_register layout: enable is bit 5, polarity bit 4
  typedef struct packed {
    logic [1:0] unused_hi;
    logic enable;
    logic polarity;
    logic unused_lo;
    logic slave;
    logic [1:0] rate;
  } sssp_ctrl_t;

  typedef struct packed {
    logic write_collision_bit;
    logic buffer_full_bit;
    logic port_interrupt_flag;
    logic wake;
  } sssp_stat_t;

  typedef struct packed {
    logic serial_out_pin;
    logic sdo_oe;
    logic sck;
    logic sck_oe;
  } sssp_pin_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } sssp_state_t;
endpackage

// >>> src/sssp_port.sv
`timescale 1ns/1ps
// What this block does
// - port works only while enable bit 5 of control is set; pins go serial
// - opposite direction bit releases that pin from the serial function
// - drive on one clock edge, sample on the other; polarities must match
// - master starts a word at once when software writes the buffer
// - master with clock pin as input keeps receiving bytes at the rate
// - slave shifts only on external clock; flag set on final bit
// - clock idle level and active edges follow polarity bit 4
// - words shift most significant bit first both ways, both modes
// - slave keeps working in sleep and completion wakes the device
// - only master starts transfers; slave answers only when clocked
// - after eight bits buffer loads, full bit and interrupt flag set
// - write during transfer is dropped and sets sticky collision bit
// - reading the buffer clears the full bit
module sssp_port
  import sssp_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // configuration
  input sssp_ctrl_t port_control_register,
  input wire logic [7:0] port_c_direction,
  input wire logic [5:0] port_a_direction,
  input wire logic sleep_mode,
  input wire logic timer2_tick,
  // software access to the buffer and flags
  input wire logic buf_wr,
  input wire logic [7:0] buf_wr_data,
  input wire logic buf_rd,
  input wire logic write_collision_bit_clr,
  input wire logic irq_clr,
  output logic [7:0] transfer_buffer,
  output sssp_stat_t status,
  // serial pins
  input wire logic serial_in_pin,
  input wire logic sck_in,
  input wire logic ss_n_pin,
  output sssp_pin_t pins
);

  sssp_ctrl_t ctrl;
  sssp_state_t state;
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic sck_d;
  logic [5:0] half_cnt;
  logic [4:0] edge_cnt;
  logic [2:0] bit_cnt;
  logic [7:0] shift_register;

  assign ctrl = port_control_register;

  // mode and pin ownership decode
  wire ena = ctrl.enable;
  wire master = ena & ~ctrl.slave;
  wire slv = ena & ctrl.slave;
  wire sdi_used = port_c_direction[DIR_C_SDI];
  wire sdo_used = ~port_c_direction[DIR_C_SDO];
  wire sck_drive = master & ~port_c_direction[DIR_C_SCK];
  wire sck_listen = slv & port_c_direction[DIR_C_SCK];
  wire ss_used = port_a_direction[DIR_A_SS];
  wire selected = ~ss_used | ~sync2[2];
  wire sdi_bit = sdi_used & sync2[0];

  // master bit rate; timer2 ticks toggle the clock so the rate is halved
  wire [5:0] half_lim = (ctrl.rate == RATE_DIV4) ? HALF_DIV4 :
                        (ctrl.rate == RATE_DIV16) ? HALF_DIV16 : HALF_DIV64;
  wire half_tick = (ctrl.rate == RATE_TMR2) ? timer2_tick :
                   (half_cnt == half_lim - 6'h01);

  // transfer progress
  wire m_busy = (state == ST_RUN);
  wire s_busy = (bit_cnt != 3'h0);
  wire busy = m_busy | s_busy;
  wire wr_ok = buf_wr & ena & ~busy;
  wire wr_col = buf_wr & ena & busy;
  // a receive-only master, clock pin released, free-runs byte after byte
  wire m_start = master & ~m_busy & (buf_wr | ~sck_drive);
  wire m_lead = m_busy & half_tick & ~edge_cnt[0];
  wire m_trail = m_busy & half_tick & edge_cnt[0];
  wire m_end = m_trail & (edge_cnt == LAST_TRAIL);
  // slave edges come only from the synchronised external clock
  wire s_edge = sck_listen & selected & (sync2[1] != sck_d);
  wire s_lead = s_edge & (sync2[1] != ctrl.polarity);
  wire s_trail = s_edge & (sync2[1] == ctrl.polarity);
  wire lead = m_lead | s_lead;
  wire trail = m_trail | s_trail;
  wire done = (m_lead & (edge_cnt == LAST_LEAD)) |
              (s_lead & (bit_cnt == LAST_BIT));
  wire [7:0] rx_word = {shift_register[6:0], sdi_bit};

  // pin synchronisers; stage one feeds stage two only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 3'h0;
      sync2 <= 3'h0;
      sck_d <= 1'b0;
    end else begin
      sync1 <= {ss_n_pin, sck_in, serial_in_pin};
      sync2 <= sync1;
      sck_d <= sync2[1];
    end
  end

  // master sequencer: sixteen clock half periods per word
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: if (m_start) state <= ST_RUN;
        ST_RUN: if (!master || m_end) state <= ST_IDLE;
      endcase
    end
  end

  // half period divider and edge counter
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      half_cnt <= 6'h00;
      edge_cnt <= 5'h00;
    end else if (!m_busy || half_tick) begin
      half_cnt <= 6'h00;
      edge_cnt <= m_busy ? edge_cnt + 5'h01 : 5'h00;
    end else begin
      half_cnt <= half_cnt + 6'h01;
    end
  end

  // slave bit counter; deselect or disable drops a partial word
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt <= 3'h0;
    end else if (!sck_listen || !selected) begin
      bit_cnt <= 3'h0;
    end else if (s_lead) begin
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  // shift register: msb leaves first, new bit enters at the bottom
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_register <= 8'h00;
    end else if (wr_ok) begin
      shift_register <= buf_wr_data;
    end else if (lead) begin
      shift_register <= rx_word;
    end
  end

  // buffer keeps the written word until a received word replaces it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      transfer_buffer <= 8'h00;
    end else if (done) begin
      transfer_buffer <= rx_word;
    end else if (wr_ok) begin
      transfer_buffer <= buf_wr_data;
    end
  end

  // sticky flags and a one-cycle wake pulse; a set in the clearing cycle wins
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
    end else begin
      status.buffer_full_bit <= done | (status.buffer_full_bit & ~buf_rd);
      status.port_interrupt_flag <= done | (status.port_interrupt_flag & ~irq_clr);
      status.write_collision_bit <= wr_col |
                                    (status.write_collision_bit & ~write_collision_bit_clr);
      status.wake <= done & slv & sleep_mode;
    end
  end

  // pin drivers; data moves on the trailing edge, first bit at load
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pins <= '0;
    end else begin
      pins.sdo_oe <= ena & sdo_used & (master | selected);
      pins.sck_oe <= sck_drive;
      if (wr_ok) begin
        pins.serial_out_pin <= buf_wr_data[7];
      end else if (trail) begin
        pins.serial_out_pin <= shift_register[7];
      end
      if (!m_busy) begin
        pins.sck <= ctrl.polarity;
      end else if (half_tick) begin
        pins.sck <= ~pins.sck;
      end
    end
  end

  // checks on the logic above
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  property p_disabled_quiet;
    !ena |=> !pins.sck_oe && !pins.sdo_oe;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("pins driven while port disabled");

  property p_sdo_released;
    port_c_direction[DIR_C_SDO] |=> !pins.sdo_oe;
  endproperty
  a_sdo_released: assert property (p_sdo_released)
    else $error("data out driven although direction is input");

  property p_write_starts;
    (master && wr_ok) |=> (state == ST_RUN) ##1 (state == ST_RUN);
  endproperty
  a_write_starts: assert property (p_write_starts)
    else $error("master did not start after buffer write");

  property p_collision;
    (wr_col && !done) |=> status.write_collision_bit && $stable(transfer_buffer);
  endproperty
  a_collision: assert property (p_collision)
    else $error("write during transfer not flagged or not dropped");

  property p_word_done;
    done |=> status.buffer_full_bit && status.port_interrupt_flag;
  endproperty
  a_word_done: assert property (p_word_done)
    else $error("full bit or interrupt flag missing after word");

  property p_read_clears;
    (buf_rd && !done) |=> !status.buffer_full_bit;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("buffer read did not clear full bit");

  property p_idle_level;
    (!m_busy && master && $stable(ctrl.polarity)) |=> pins.sck == ctrl.polarity;
  endproperty
  a_idle_level: assert property (p_idle_level)
    else $error("master clock idle level wrong");

  property p_rate_div4;
    (m_busy && !m_end && half_tick && ctrl.rate == RATE_DIV4 && $stable(ctrl))
      |=> !half_tick ##1 half_tick;
  endproperty
  a_rate_div4: assert property (p_rate_div4)
    else $error("osc/4 half period is not two cycles");

  property p_slave_last;
    (s_lead && bit_cnt == LAST_BIT) |=> status.port_interrupt_flag && bit_cnt == 3'h0;
  endproperty
  a_slave_last: assert property (p_slave_last)
    else $error("slave final bit did not raise flag");

  property p_wake;
    (done && slv && sleep_mode) |=> status.wake ##1 !status.wake;
  endproperty
  a_wake: assert property (p_wake)
    else $error("slave completion in sleep gave no wake pulse");

  // flags are sticky: only their own clear may drop them
  property p_full_sticky;
    (status.buffer_full_bit && !buf_rd) |=> status.buffer_full_bit;
  endproperty
  a_full_sticky: assert property (p_full_sticky)
    else $error("full bit dropped without a buffer read");

  property p_write_collision_bit_sticky;
    (status.write_collision_bit && !write_collision_bit_clr) |=> status.write_collision_bit;
  endproperty
  a_write_collision_bit_sticky: assert property (p_write_collision_bit_sticky)
    else $error("collision bit dropped without its clear");

  property p_disabled_write;
    (buf_wr && !ena && !done) |=> $stable(transfer_buffer);
  endproperty
  a_disabled_write: assert property (p_disabled_write)
    else $error("write accepted while port disabled");

  property p_first_bit;
    wr_ok |=> pins.serial_out_pin == $past(buf_wr_data[7]);
  endproperty
  a_first_bit: assert property (p_first_bit)
    else $error("first data out bit is not the msb of the written word");

  property p_slave_no_clock;
    slv |=> !pins.sck_oe && state == ST_IDLE;
  endproperty
  a_slave_no_clock: assert property (p_slave_no_clock)
    else $error("slave drove the clock or ran the master sequencer");

  property p_wake_only_slave;
    !(slv && sleep_mode) |=> !status.wake;
  endproperty
  a_wake_only_slave: assert property (p_wake_only_slave)
    else $error("wake pulse outside slave sleep");

endmodule

// >>> sim/sssp_peer.sv
`timescale 1ns/1ps
// far side controller: slave while the port drives the clock, master otherwise
module sssp_peer (
  // configuration seen from the port
  input wire logic polarity,
  input wire logic dut_sck_oe,
  // link
  input wire logic dut_sck,
  input wire logic dut_sdo,
  output logic sck_line,
  output logic peer_out
);
  logic peer_act = 1'b0;
  logic [7:0] tx = 8'h00;
  logic [7:0] rx = 8'h00;
  // only the master makes the clock; an idle master holds the polarity level
  assign sck_line = dut_sck_oe ? dut_sck : (peer_act ^ polarity);
  assign peer_out = tx[7];
  // leading edge samples while the port drives the clock, trailing edge shifts; the fill toggles so stale bits never look valid
  always @(sck_line) begin
    if (sck_line !== polarity && dut_sck_oe) rx = {rx[6:0], dut_sdo};
    else if (sck_line === polarity) tx = {tx[6:0], ~tx[0]};
  end
  // one word at the link rate; sample late in the active phase since the slave is synchronised
  task automatic xfer();
    repeat (8) begin
      #160 peer_act = 1'b1;
      #155 rx = {rx[6:0], dut_sdo};
      #5 peer_act = 1'b0;
    end
  endtask
endmodule

// >>> sim/sssp_port_test.sv
`timescale 1ns/1ps
module sssp_port_test;
  import sssp_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  sssp_ctrl_t ctrl = '0;
  logic [7:0] dir_c = 8'h10;
  logic [5:0] dir_a = 6'h20;
  logic sleep_mode = 1'b0;
  logic timer2_tick = 1'b0;
  logic buf_wr = 1'b0;
  logic [7:0] buf_wr_data = 8'h00;
  logic buf_rd = 1'b0;
  logic write_collision_bit_clr = 1'b0;
  logic irq_clr = 1'b0;
  logic ss_n = 1'b1;
  logic [7:0] transfer_buffer;
  sssp_stat_t status;
  sssp_pin_t pins;
  logic sck_line;
  logic peer_out;
  logic wake_seen = 1'b0;
  logic [7:0] pb;
  int mismatches = 0;
  int total_checks = 0;
  int n;
  int t2 = 0;
  logic [5:0] half [4] = '{HALF_DIV4, HALF_DIV16, HALF_DIV64, 6'h04};

  // clock, timer2 pulse every fourth cycle, and a catcher for the one-cycle wake pulse
  always #20 sys_clk = ~sys_clk;
  always @(negedge sys_clk) begin
    t2 = t2 + 1;
    timer2_tick = (t2 % 4 == 0);
  end
  always @(negedge sys_clk) if (status.wake === 1'b1) wake_seen <= 1'b1;

  sssp_port dut (.sys_clk(sys_clk), .rst_n(rst_n), .port_control_register(ctrl),
    .port_c_direction(dir_c), .port_a_direction(dir_a), .sleep_mode(sleep_mode),
    .timer2_tick(timer2_tick), .buf_wr(buf_wr), .buf_wr_data(buf_wr_data),
    .buf_rd(buf_rd), .write_collision_bit_clr(write_collision_bit_clr), .irq_clr(irq_clr),
    .transfer_buffer(transfer_buffer), .status(status), .serial_in_pin(peer_out),
    .sck_in(sck_line), .ss_n_pin(ss_n), .pins(pins));
  sssp_peer peer (.polarity(ctrl.polarity), .dut_sck_oe(pins.sck_oe), .dut_sck(pins.sck),
    .dut_sdo(pins.serial_out_pin), .sck_line(sck_line), .peer_out(peer_out));

  task automatic test_done();
    if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge sys_clk) s = 1'b1;
    @(negedge sys_clk) s = 1'b0;
  endtask
  task automatic wr(input logic [7:0] d);
    buf_wr_data = d;
    pulse(buf_wr);
  endtask
  // reconfigure only with the port disabled, then enable again
  task automatic cfg(input logic [1:0] rate, input logic pol, input logic slv);
    @(negedge sys_clk) ctrl.enable = 1'b0;
    @(negedge sys_clk) ctrl = '{2'h0, 1'b0, pol, 1'b0, slv, rate};
    @(negedge sys_clk) ctrl.enable = 1'b1;
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic wait_full(output int c);
    c = 0;
    while (status.buffer_full_bit !== 1'b1) begin
      @(negedge sys_clk) c++;
      if (c > 3000) begin
        mismatches++;
        test_done();
      end
    end
  endtask

  initial begin
    repeat (2) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    // every master rate, polarity alternating; div4 gets a steady peer line
    for (int i = 0; i < 4; i++) begin
      cfg(i[1:0], i[0], 1'b0);
      pb = (i == 0) ? 8'h00 : 8'hc3;
      peer.tx = pb;
      check(8'(pins.sck), 8'(i[0]));
      check({6'h0, pins.sdo_oe, pins.sck_oe}, 8'h03);
      wr(8'ha5 ^ 8'(i));
      wait_full(n);
      check(8'(n >= 14 * half[i] && n <= 16 * half[i] + 4), 8'h01);
      check(transfer_buffer, pb);
      check(peer.rx, 8'ha5 ^ 8'(i));
      check({6'h0, status.port_interrupt_flag, status.buffer_full_bit}, 8'h03);
      pulse(buf_rd);
      pulse(irq_clr);
      check(8'(status.buffer_full_bit), 8'h00);
    end
    // a write in mid-word is dropped and flagged until cleared
    cfg(RATE_DIV64, 1'b0, 1'b0);
    peer.tx = 8'h81;
    wr(8'h3c);
    wr(8'hff);
    @(negedge sys_clk);
    check(8'(status.write_collision_bit), 8'h01);
    wait_full(n);
    check(peer.rx, 8'h3c);
    check(transfer_buffer, 8'h81);
    check(8'(status.write_collision_bit), 8'h01);
    pulse(write_collision_bit_clr);
    @(negedge sys_clk);
    check(8'(status.write_collision_bit), 8'h00);
    pulse(buf_rd);
    // clock pin as input in master mode: receive-only, byte after byte
    dir_c = 8'h18;
    cfg(RATE_DIV16, 1'b0, 1'b0);
    peer.tx = 8'hff;
    check(8'(pins.sck_oe), 8'h00);
    wait_full(n);
    check(transfer_buffer, 8'hff);
    pulse(buf_rd);
    wait_full(n);
    check(8'(status.buffer_full_bit), 8'h01);
    pulse(buf_rd);
    // slave asleep, selected, waits for the far master's clock
    ss_n = 1'b0;
    sleep_mode = 1'b1;
    cfg(RATE_DIV4, 1'b1, 1'b1);
    pulse(irq_clr);
    peer.tx = 8'h69;
    wr(8'h96);
    repeat (40) @(negedge sys_clk);
    check(8'(status.buffer_full_bit), 8'h00);
    peer.xfer();
    repeat (6) @(negedge sys_clk);
    check(transfer_buffer, 8'h69);
    check(peer.rx, 8'h96);
    check({6'h0, status.port_interrupt_flag, wake_seen}, 8'h03);
    // data-out direction turned to input takes the pin away from the port
    check({6'h0, pins.sdo_oe, pins.sck_oe}, 8'h02);
    dir_c = 8'h38;
    repeat (2) @(negedge sys_clk);
    check({6'h0, pins.sdo_oe, pins.sck_oe}, 8'h00);
    // disabled port ignores writes and releases its pins
    @(negedge sys_clk) ctrl.enable = 1'b0;
    wr(8'h11);
    repeat (4) @(negedge sys_clk);
    check(transfer_buffer, 8'h69);
    check({6'h0, pins.sdo_oe, pins.sck_oe}, 8'h00);
    test_done();
  end
endmodule
